// File: inc/phv_defs.svh
// Register map, field positions, reset values and counts of the playback path
`ifndef PHV_DEFS_SVH
`define PHV_DEFS_SVH

`define PHV_ADDR_CTRL 12'h000
`define PHV_ADDR_PCM_VOL 12'h004
`define PHV_ADDR_PDM_VOL 12'h008
`define PHV_ADDR_STATUS 12'h00c

`define PHV_F_CORNER 2:0
`define PHV_F_RATEMUL 4:3
`define PHV_F_RAMP 6:5
`define PHV_F_SRC 7
`define PHV_F_AMP 12:8
`define PHV_F_VOL 7:0

`define PHV_CORNER_RST 3'h1
`define PHV_CORNER_BYPASS 3'h0
`define PHV_CORNER_RSVD 3'h7
`define PHV_RATEMUL_RST 2'h0
`define PHV_RATEMUL_RSVD 2'h3
`define PHV_RAMP_RST 2'h0
`define PHV_RAMP_EVERY4 2'h1
`define PHV_RAMP_EVERY8 2'h2
`define PHV_RAMP_OFF 2'h3
`define PHV_RAMP_CNT1 3'h0
`define PHV_RAMP_CNT4 3'h3
`define PHV_RAMP_CNT8 3'h7
`define PHV_AMP_RST 5'h10
`define PHV_AMP_MAX 5'h14
`define PHV_VOL_RST 8'h00
`define PHV_VOL_MAX 8'hc8
`define PHV_VOL_MUTE 8'hc9
`define PHV_STEPS_6DB 8'h0c
`define PHV_HPF_FRAC 8
`define PHV_FIFO_DEPTH 8

`endif

// File: inc/phv_pkg.sv
// Types shared by the playback path modules
package phv_pkg;
    typedef logic signed [15:0] phv_sample_t;
    typedef struct packed {
        logic pdm;
        phv_sample_t s;
    } phv_item_t;
    localparam int PHV_ITEM_W = $bits(phv_item_t);
endpackage : phv_pkg

// File: inc/phv_stream_if.sv
// Valid/ready stream carrier between the path and its sample FIFO
`timescale 1ns/1ps
interface phv_stream_if #(parameter int W = 17);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport prod (output valid, output data, input ready);
    modport cons (input valid, input data, output ready);
endinterface : phv_stream_if

// File: verilog/phv_fifo.sv
// Sample FIFO with registered full and empty flags
`timescale 1ns/1ps
module phv_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    phv_stream_if.cons wr,
    phv_stream_if.prod rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic full_reg;
    logic empty_reg;
    wire push = wr.valid & ~full_reg;
    wire pop = rd.ready & ~empty_reg;

    assign wr.ready = ~full_reg;
    assign rd.valid = ~empty_reg;
    assign rd.data = mem[rptr_reg];
    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wptr_reg <= push ? AW'((wptr_reg + 1'b1) % DEPTH) : wptr_reg;
            rptr_reg <= pop ? AW'((rptr_reg + 1'b1) % DEPTH) : rptr_reg;
            cnt_reg <= cnt_next;
            full_reg <= (cnt_next == FULL_CNT);
            empty_reg <= (cnt_next == '0);
        end
    end
endmodule : phv_fifo

// File: verilog/phv_path.sv
// Playback high-pass filter and dual digital volume path with APB registers
//
// Overview of operation
// (RULE1) The high-pass filter acts on PCM samples only, never on PDM samples.
// (RULE2) A corner code of zero bypasses the filter so PCM passes unfiltered.
// (RULE3) Codes 1-6 give corners 1.8-735 Hz in the 44.1 kHz family, 1 resets, 7 is reserved.
// (RULE4) The same codes give 2-800 Hz in the 48 kHz family, 7 reserved.
// (RULE5) PCM and PDM streams each have their own volume setting.
// (RULE6) A 5-bit level code sets 11 to 21 dBV in 0.5 dB steps, resets to 0x10, above 0x14 reserved.
// (RULE7) Each volume count attenuates 0.5 dB, 0x00 is 0 dB and resets, 0xc8 is -100 dB.
// (RULE8) Volume codes 0xc9 to 0xff mute their stream.
// (RULE9) On a volume change the applied attenuation moves gradually unless ramping is off.
// (RULE10) Ramp code 0 steps every sample, 1 every 4 samples, 2 every 8 samples.
// (RULE11) Ramp code 3 applies a new volume at once.
// (RULE12) A host that ramps volume itself should turn device ramping off.
// (RULE13) The source bit picks PCM when zero and PDM when one.
// (RULE14) A ramp stops exactly on target and restarts from the applied value on a new target.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "phv_defs.svh"
module phv_path (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire phv_pkg::phv_sample_t pcm_data,
    input wire logic pcm_valid,
    input wire phv_pkg::phv_sample_t pdm_data,
    input wire logic pdm_valid,
    output logic sample_in_ready,
    output phv_pkg::phv_sample_t out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [4:0] amp_level
);
    import phv_pkg::*;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] vol_mant(input logic [3:0] idx);
        unique case (idx)
            4'h0: vol_mant = 16'h8000;
            4'h1: vol_mant = 16'h78d7;
            4'h2: vol_mant = 16'h7215;
            4'h3: vol_mant = 16'h6bb3;
            4'h4: vol_mant = 16'h65ad;
            4'h5: vol_mant = 16'h5ffd;
            4'h6: vol_mant = 16'h5a9e;
            4'h7: vol_mant = 16'h558c;
            4'h8: vol_mant = 16'h50c3;
            4'h9: vol_mant = 16'h4c3f;
            4'ha: vol_mant = 16'h47fb;
            4'hb: vol_mant = 16'h43f4;
            default: vol_mant = 16'h0000;
        endcase
    endfunction : vol_mant

    function automatic logic [4:0] corner_shift(input logic [2:0] code, input logic [1:0] mul);
        logic [4:0] base;
        base = 5'h0;
        // Pole at 1-2^-k puts the corner near fs*2^-k/(2*pi)
        unique case (code)
            3'h1: base = 5'h0c;
            3'h2: base = 5'h07;
            3'h3: base = 5'h06;
            3'h4: base = 5'h05;
            3'h5: base = 5'h04;
            3'h6: base = 5'h03;
            default: base = 5'h00;
        endcase
        corner_shift = base + {3'h0, mul};
    endfunction : corner_shift

    function automatic logic [7:0] vol_target(input logic [7:0] code);
        vol_target = (code > `PHV_VOL_MAX) ? `PHV_VOL_MUTE : code;
    endfunction : vol_target

    // ------------------------------------------------------------
    // APB register slave
    // ------------------------------------------------------------
    logic [2:0] corner_reg;
    logic [1:0] ratemul_reg;
    logic [1:0] ramp_reg;
    logic src_reg;
    logic [4:0] amp_reg;
    logic [7:0] vol_code_reg [2];
    logic [7:0] att_reg [2];
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_mux;
    logic fifo_full_seen;

    wire acc = psel & penable & pready_reg;
    wire wr_en = acc & pwrite;
    wire hit_ctrl = (paddr == `PHV_ADDR_CTRL);
    wire hit_pcm = (paddr == `PHV_ADDR_PCM_VOL);
    wire hit_pdm = (paddr == `PHV_ADDR_PDM_VOL);
    wire hit_stat = (paddr == `PHV_ADDR_STATUS);
    wire addr_ok = hit_ctrl | hit_pcm | hit_pdm | hit_stat;
    wire wr_ctrl = wr_en & hit_ctrl;
    wire [2:0] wr_corner = pwdata[`PHV_F_CORNER];
    wire [1:0] wr_ratemul = pwdata[`PHV_F_RATEMUL];
    wire [4:0] wr_amp = pwdata[`PHV_F_AMP];
    wire corner_ok = (wr_corner != `PHV_CORNER_RSVD);
    wire ratemul_ok = (wr_ratemul != `PHV_RATEMUL_RSVD);
    wire amp_ok = (wr_amp <= `PHV_AMP_MAX);
    wire ramping = (att_reg[0] != vol_target(vol_code_reg[0]))
                 | (att_reg[1] != vol_target(vol_code_reg[1]));

    assign rd_mux = hit_ctrl ? {19'h0, amp_reg, src_reg, ramp_reg, ratemul_reg, corner_reg}
                  : hit_pcm ? {24'h0, vol_code_reg[0]}
                  : hit_pdm ? {24'h0, vol_code_reg[1]}
                  : hit_stat ? {14'h0, fifo_full_seen, ramping, att_reg[1], att_reg[0]}
                  : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= psel & ~penable & ~pready_reg;
            pslverr_reg <= psel & ~penable & ~addr_ok;
            prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // Reserved codes are refused and the old value kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corner_reg <= `PHV_CORNER_RST;
            ratemul_reg <= `PHV_RATEMUL_RST;
            ramp_reg <= `PHV_RAMP_RST;
            src_reg <= 1'b0;
            amp_reg <= `PHV_AMP_RST;
        end else if (wr_ctrl) begin
            corner_reg <= corner_ok ? wr_corner : corner_reg; // [RULE3] [RULE4]
            ratemul_reg <= ratemul_ok ? wr_ratemul : ratemul_reg;
            ramp_reg <= pwdata[`PHV_F_RAMP]; // [RULE10]
            src_reg <= pwdata[`PHV_F_SRC]; // [RULE13]
            amp_reg <= amp_ok ? wr_amp : amp_reg; // [RULE6]
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign amp_level = amp_reg;

    // ------------------------------------------------------------
    // Source selection into the sample FIFO
    // ------------------------------------------------------------
    phv_stream_if #(.W(PHV_ITEM_W)) fin ();
    phv_stream_if #(.W(PHV_ITEM_W)) fout ();
    phv_item_t in_item;
    phv_item_t head;

    assign in_item.pdm = src_reg; // [RULE13]
    assign in_item.s = src_reg ? pdm_data : pcm_data;
    assign fin.valid = src_reg ? pdm_valid : pcm_valid;
    assign fin.data = in_item;
    assign sample_in_ready = fin.ready;
    assign head = fout.data;

    phv_fifo #(.W(PHV_ITEM_W), .DEPTH(`PHV_FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .wr(fin),
        .rd(fout)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_full_seen <= 1'b0;
        end else begin
            fifo_full_seen <= ~fin.ready;
        end
    end

    // ------------------------------------------------------------
    // High-pass filter
    // ------------------------------------------------------------
    logic out_valid_reg;
    phv_sample_t out_data_reg;
    logic signed [25:0] hx_reg;
    logic signed [25:0] hy_reg;

    assign fout.ready = ~out_valid_reg | out_ready;
    wire pop = fout.valid & fout.ready;
    wire hpf_on = ~head.pdm & (corner_reg != `PHV_CORNER_BYPASS); // [RULE1] [RULE2]
    wire [4:0] hshift = corner_shift(corner_reg, ratemul_reg); // [RULE3] [RULE4]
    wire signed [25:0] hx = 26'(head.s) <<< `PHV_HPF_FRAC;
    wire signed [25:0] hy = hx - hx_reg + hy_reg - (hy_reg >>> hshift);
    wire signed [25:0] hy_int = hy >>> `PHV_HPF_FRAC;
    wire hy_hi = hy_int > 26'sh0007fff;
    wire hy_lo = hy_int < -26'sh0008000;
    wire phv_sample_t hy_sat = hy_hi ? 16'sh7fff : hy_lo ? -16'sh8000 : hy_int[15:0];
    wire phv_sample_t filt = hpf_on ? hy_sat : head.s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hx_reg <= '0;
            hy_reg <= '0;
        end else if (pop & hpf_on) begin
            hx_reg <= hx;
            hy_reg <= hy;
        end
    end

    // ------------------------------------------------------------
    // Volume ramp, one attenuation per stream on one shared step counter
    // ------------------------------------------------------------
    logic [2:0] ramp_cnt_reg;
    wire [2:0] ramp_top = (ramp_reg == `PHV_RAMP_EVERY4) ? `PHV_RAMP_CNT4
                        : (ramp_reg == `PHV_RAMP_EVERY8) ? `PHV_RAMP_CNT8
                        : `PHV_RAMP_CNT1; // [RULE10]
    wire ramp_step = pop & (ramp_cnt_reg >= ramp_top);
    wire ramp_off = (ramp_reg == `PHV_RAMP_OFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_cnt_reg <= 3'h0;
        end else if (pop) begin
            ramp_cnt_reg <= ramp_step ? 3'h0 : ramp_cnt_reg + 3'h1;
        end
    end

    wire [1:0] vol_wr = {wr_en & hit_pdm, wr_en & hit_pcm}; // [RULE5]
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_vol
            wire [7:0] tgt = vol_target(vol_code_reg[gi]); // [RULE8]
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vol_code_reg[gi] <= `PHV_VOL_RST;
                    att_reg[gi] <= `PHV_VOL_RST;
                end else begin
                    if (vol_wr[gi]) begin
                        vol_code_reg[gi] <= pwdata[`PHV_F_VOL];
                    end
                    if (ramp_off) begin
                        att_reg[gi] <= tgt; // [RULE11]
                    end else if (ramp_step && att_reg[gi] < tgt) begin
                        att_reg[gi] <= att_reg[gi] + 8'h1; // [RULE9] [RULE14]
                    end else if (ramp_step && att_reg[gi] > tgt) begin
                        att_reg[gi] <= att_reg[gi] - 8'h1; // [RULE9] [RULE14]
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Gain stage and output register
    // ------------------------------------------------------------
    wire [7:0] att = head.pdm ? att_reg[1] : att_reg[0]; // [RULE5]
    wire [7:0] att_exp = att / `PHV_STEPS_6DB; // [RULE7]
    wire [7:0] att_idx = att % `PHV_STEPS_6DB;
    wire [15:0] mant = vol_mant(att_idx[3:0]);
    wire signed [32:0] prod = filt * $signed({1'b0, mant});
    wire signed [32:0] scaled = (prod >>> 15) >>> att_exp;
    wire phv_sample_t gained = (att > `PHV_VOL_MAX) ? 16'sh0000 : scaled[15:0]; // [RULE8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (fout.ready) begin
            out_valid_reg <= fout.valid;
            out_data_reg <= fout.valid ? gained : out_data_reg;
        end
    end

    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pdm_unfiltered;
        pop & head.pdm & (att_reg[1] == 8'h0) |=> out_valid && out_data == $past(head.s);
    endproperty
    a_pdm_unfiltered: assert property (p_pdm_unfiltered) // [RULE1]
        else $error("pdm sample was altered at 0 dB");

    property p_bypass;
        pop & ~head.pdm & (corner_reg == 3'h0) & (att_reg[0] == 8'h0)
            |=> out_data == $past(head.s);
    endproperty
    a_bypass: assert property (p_bypass) // [RULE2]
        else $error("bypassed pcm sample was altered");

    property p_corner_rsvd;
        wr_ctrl & (wr_corner == 3'h7) |=> corner_reg == $past(corner_reg) && corner_reg != 3'h7;
    endproperty
    a_corner_rsvd: assert property (p_corner_rsvd) // [RULE3] [RULE4]
        else $error("reserved corner code was taken");

    property p_vol_indep;
        wr_en & hit_pcm |=> $stable(vol_code_reg[1]);
    endproperty
    a_vol_indep: assert property (p_vol_indep) // [RULE5]
        else $error("pcm volume write touched pdm volume");

    property p_amp_range;
        amp_level <= 5'h14;
    endproperty
    a_amp_range: assert property (p_amp_range) // [RULE6]
        else $error("amplifier level code is reserved");

    property p_mute;
        pop & (att > 8'hc8) |=> out_data == 16'sh0000;
    endproperty
    a_mute: assert property (p_mute) // [RULE8]
        else $error("muted stream produced nonzero data");

    property p_step_one;
        ~ramp_off & $past(~ramp_off) & (att_reg[0] != $past(att_reg[0]))
            |-> (att_reg[0] - $past(att_reg[0]) == 8'h1)
             || ($past(att_reg[0]) - att_reg[0] == 8'h1);
    endproperty
    a_step_one: assert property (p_step_one) // [RULE9] [RULE10]
        else $error("pcm attenuation jumped by more than one step");

    property p_ramp_off;
        ramp_off |=> att_reg[1] == vol_target($past(vol_code_reg[1]));
    endproperty
    a_ramp_off: assert property (p_ramp_off) // [RULE11]
        else $error("ramp off did not apply volume at once");

    property p_stop_on_target;
        (att_reg[0] == vol_target(vol_code_reg[0])) & ~vol_wr[0] |=> $stable(att_reg[0]);
    endproperty
    a_stop_on_target: assert property (p_stop_on_target) // [RULE14]
        else $error("ramp moved past its target");

    property p_src_tag;
        fin.valid & fin.ready |-> in_item.pdm == src_reg && in_item.s == (src_reg ? pdm_data : pcm_data);
    endproperty
    a_src_tag: assert property (p_src_tag) // [RULE13]
        else $error("sample tagged with wrong source");

    c_fifo_full: cover property (~fin.ready);
    c_ramp_down: cover property (ramp_step & (att_reg[0] > vol_target(vol_code_reg[0])));
    c_pdm_pop: cover property (pop & head.pdm);
    c_hpf_pop: cover property (pop & hpf_on);
endmodule : phv_path

// File: tb/phv_src_model.sv
// Sample source model for the PCM and PDM inputs of the playback path
`timescale 1ns/1ps
module phv_src_model (
    input wire logic pclk,
    input wire logic ready,
    output phv_pkg::phv_sample_t pcm_data,
    output logic pcm_valid,
    output phv_pkg::phv_sample_t pdm_data,
    output logic pdm_valid
);
    import phv_pkg::*;
    initial begin
        pcm_valid = 1'b0;
        pdm_valid = 1'b0;
        pcm_data = '0;
        pdm_data = '0;
    end
    // Both set: offer the sample on the unselected stream as well
    task automatic send(input logic pdm, input logic both, input phv_sample_t d);
        int n;
        n = 0;
        @(posedge pclk);
        if (pdm || both) begin
            pdm_data <= d;
            pdm_valid <= 1'b1;
        end
        if (!pdm || both) begin
            pcm_data <= d;
            pcm_valid <= 1'b1;
        end
        do begin
            @(posedge pclk);
            n++;
        end while (ready !== 1'b1 && n < 200);
        pcm_valid <= 1'b0;
        pdm_valid <= 1'b0;
        // Released lines must not keep showing the sample
        pcm_data <= ~d;
        pdm_data <= ~d;
    endtask : send
endmodule : phv_src_model

// File: tb/tb_top.sv
// Self-checking bench of the playback path
`timescale 1ns/1ps
`include "phv_defs.svh"
module tb_top;
    import phv_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    phv_sample_t pcm_data;
    phv_sample_t pdm_data;
    logic pcm_valid;
    logic pdm_valid;
    logic sample_in_ready;
    phv_sample_t out_data;
    logic out_valid;
    logic out_ready = 1'b0;
    logic [4:0] amp_level;
    logic sink_on = 1'b1;
    logic [31:0] rq;
    logic re;
    phv_sample_t outq[$];
    phv_sample_t sentq[$];
    int error_cnt = 0;
    int cmp_count = 0;
    always #25 pclk = ~pclk;
    phv_path phv_path_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pcm_data(pcm_data), .pcm_valid(pcm_valid),
        .pdm_data(pdm_data), .pdm_valid(pdm_valid), .sample_in_ready(sample_in_ready),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .amp_level(amp_level));
    phv_src_model src (.pclk(pclk), .ready(sample_in_ready), .pcm_data(pcm_data),
        .pcm_valid(pcm_valid), .pdm_data(pdm_data), .pdm_valid(pdm_valid));
    // ----
    // Sink with random stalls
    // ----
    always @(posedge pclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            outq.push_back(out_data);
        end
        out_ready <= sink_on && ($urandom_range(3) != 0);
    end
    // ----
    // Tasks
    // ----
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_s(input string nm, input phv_sample_t e, input phv_sample_t g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_s
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rq & m);
    endtask : rd_chk
    task automatic xfer(input logic pdm, input logic both, input phv_sample_t d,
                        output phv_sample_t q);
        int n;
        n = 0;
        src.send(pdm, both, d);
        while (outq.size() == 0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (outq.size() > 0) begin
            q = outq.pop_front();
        end else begin
            error_cnt++;
            q = 'x;
        end
    endtask : xfer
    function automatic phv_sample_t scale(phv_sample_t x, logic [7:0] att);
        if (att > `PHV_VOL_MAX) begin
            return '0;
        end
        return x >>> (att / 12);
    endfunction : scale
    // ----
    // Main sequence
    // ----
    initial begin
        #2_000_000;
        error_cnt++;
        end_sim();
    end
    initial begin
        logic [7:0] atts[6];
        logic [7:0] att;
        phv_sample_t d;
        phv_sample_t q;
        int cnt;
        int n;
        atts = '{8'h00, 8'h0c, 8'h18, 8'h30, 8'hc8, 8'hc9};
        void'($urandom(4637));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl reset", `PHV_ADDR_CTRL, 32'h1fff, 32'h1001);
        chk("amp_level reset", 32'h10, {27'h0, amp_level});
        rd_chk("pcm vol reset", `PHV_ADDR_PCM_VOL, 32'hff, 32'h0);
        rd_chk("pdm vol reset", `PHV_ADDR_PDM_VOL, 32'hff, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, re});
        chk("unmapped data", 32'h0, rq);
        wr(`PHV_ADDR_CTRL, 32'h151f);
        rd_chk("ctrl reserved", `PHV_ADDR_CTRL, 32'h1fff, 32'h1001);
        wr(`PHV_ADDR_CTRL, 32'h1460);
        rd_chk("ctrl", `PHV_ADDR_CTRL, 32'h1fff, 32'h1460);
        chk("amp_level max", 32'h14, {27'h0, amp_level});
        for (int i = 0; i < 7; i++) begin
            att = (i < 6) ? atts[i] : 8'hc9 + 8'($urandom_range(54));
            wr(`PHV_ADDR_PCM_VOL, {24'h0, att});
            rd_chk("pcm att", `PHV_ADDR_STATUS, 32'h3ffff,
                   {24'h0, (att > 8'hc8) ? 8'hc9 : att});
            d = phv_sample_t'($urandom);
            xfer(1'b0, 1'b0, d, q);
            if (att != 8'hc8) begin
                chk_s("pcm out", scale(d, att), q);
            end
        end
        wr(`PHV_ADDR_CTRL, 32'h14e6);
        d = phv_sample_t'($urandom);
        xfer(1'b1, 1'b1, d, q);
        chk_s("pdm 0 dB", d, q);
        wr(`PHV_ADDR_PDM_VOL, 32'h0c);
        rd_chk("pdm att", `PHV_ADDR_STATUS, 32'hff00, 32'h0c00);
        d = phv_sample_t'($urandom);
        xfer(1'b1, 1'b1, d, q);
        chk_s("pdm out", scale(d, 8'h0c), q);
        repeat (20) @(posedge pclk);
        chk("stray out", 32'h0, outq.size());
        wr(`PHV_ADDR_CTRL, 32'h1476);
        rd_chk("ctrl rate", `PHV_ADDR_CTRL, 32'h1fff, 32'h1476);
        wr(`PHV_ADDR_CTRL, 32'h1466);
        wr(`PHV_ADDR_PCM_VOL, 32'h0);
        repeat (40) xfer(1'b0, 1'b0, 16'h4000, q);
        chk("dc decay", 32'h1, {31'h0, q < 16'sh0800});
        wr(`PHV_ADDR_CTRL, 32'h1460);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 1'b0, 16'h4000, q);
            chk_s("bypass", 16'h4000, q);
        end
        wr(`PHV_ADDR_CTRL, 32'h1400);
        wr(`PHV_ADDR_PCM_VOL, 32'h40);
        repeat (8) xfer(1'b0, 1'b0, phv_sample_t'($urandom), q);
        rd_chk("ramp 1", `PHV_ADDR_STATUS, 32'h100ff, 32'h10008);
        wr(`PHV_ADDR_CTRL, 32'h1420);
        repeat (8) xfer(1'b0, 1'b0, phv_sample_t'($urandom), q);
        rd_chk("ramp 4", `PHV_ADDR_STATUS, 32'h100ff, 32'h1000a);
        wr(`PHV_ADDR_CTRL, 32'h1440);
        repeat (8) xfer(1'b0, 1'b0, phv_sample_t'($urandom), q);
        rd_chk("ramp 8", `PHV_ADDR_STATUS, 32'h100ff, 32'h1000b);
        wr(`PHV_ADDR_CTRL, 32'h1400);
        wr(`PHV_ADDR_PCM_VOL, 32'h05);
        repeat (10) xfer(1'b0, 1'b0, phv_sample_t'($urandom), q);
        rd_chk("ramp end", `PHV_ADDR_STATUS, 32'h1ffff, 32'h00c05);
        wr(`PHV_ADDR_CTRL, 32'h1460);
        wr(`PHV_ADDR_PCM_VOL, 32'h0);
        sink_on = 1'b0;
        repeat (3) @(posedge pclk);
        cnt = 0;
        while (cnt < 12 && sample_in_ready === 1'b1) begin
            d = phv_sample_t'($urandom);
            sentq.push_back(d);
            src.send(1'b0, 1'b0, d);
            cnt++;
            @(posedge pclk);
            #1;
        end
        chk("fill count", 32'h1, {31'h0, cnt == 8 || cnt == 9});
        rd_chk("full flag", `PHV_ADDR_STATUS, 32'h20000, 32'h20000);
        sink_on = 1'b1;
        n = 0;
        while (outq.size() < cnt && n < 500) begin
            @(posedge pclk);
            n++;
        end
        chk("drain count", cnt, outq.size());
        while (outq.size() > 0 && sentq.size() > 0) begin
            chk_s("drain order", sentq.pop_front(), outq.pop_front());
        end
        end_sim();
    end
endmodule : tb_top
